/* File: crt_pkg.sv */
// Package for the coprocessor register transfer port, both ends
// Function
// RULE1 - Single move from coprocessor: LAST, one cycle
// RULE2 - Coprocessor word sampled at cycle end
// RULE3 - Single move to coprocessor: data after cycle
// RULE4 - Store-timed write data, no data address
// RULE5 - Double from coprocessor: GO, LAST, two cycles
// RULE6 - Double to coprocessor: two words, two cycles
// RULE7 - WAIT busy-waits with idle requests, held address
// RULE8 - Transfers only in 32-bit instruction state
// RULE9 - Pass high, cancel low during transfer
// RULE10 - Coprocessor drives ABSENT when not handling
// RULE11 - No coprocessor accepts: undefined instruction
package crt_pkg;
   typedef enum logic [1:0] {
      CRT_ABSENT,
      CRT_WAIT,
      CRT_GO,
      CRT_LAST
   } crt_hs_type;
   typedef enum logic [1:0] {
      CRT_OP_FROM,
      CRT_OP_TO,
      CRT_OP_DFROM,
      CRT_OP_DTO
   } crt_op_type;
   // Memory request encodings {no_mem_request, sequential}
   localparam logic [1:0] CRT_REQ_N = 2'h0;
   localparam logic [1:0] CRT_REQ_S = 2'h1;
   localparam logic [1:0] CRT_REQ_I = 2'h2;
   localparam logic [1:0] CRT_REQ_C = 2'h3;
   localparam int CRT_DATA_W = 32;
   localparam int CRT_ADDR_W = 31;
   localparam logic [31:0] CRT_DATA_RST = 32'h0;
endpackage

/* File: crt_if.sv */
// Interface joining core end and coprocessor end
`timescale 1ns/10ps
interface crt_if;
   import crt_pkg::*;
   crt_hs_type       decode_handshake;
   crt_hs_type       execute_handshake;
   logic             cp_instr_valid;
   crt_op_type       cp_op;
   logic             pass;
   logic             cancel_after_issue;
   logic [1:0]       data_req;
   logic [1:0]       instr_req;
   logic [31:0]      rdata;
   logic [31:0]      wdata;
   modport core (
      input  decode_handshake, execute_handshake, rdata,
      output cp_instr_valid, cp_op, pass, cancel_after_issue,
      output data_req, instr_req, wdata
   );
   modport coproc (
      output decode_handshake, execute_handshake, rdata,
      input  cp_instr_valid, cp_op, pass, cancel_after_issue,
      input  data_req, instr_req, wdata
   );
endinterface

/* File: crt_coproc_end.sv */
// Coprocessor end: handshake answers and register data
`timescale 1ns/10ps
module crt_coproc_end (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   // Link
   crt_if.coproc            link,
   // User side
   input  wire logic        cp_present,
   input  wire logic        cp_ready,
   input  wire logic [31:0] cp_word0,
   input  wire logic [31:0] cp_word1,
   output logic [31:0]      cp_got0,
   output logic [31:0]      cp_got1,
   output logic             cp_got_pulse
);
   import crt_pkg::*;
   logic        first_done;
   logic        is_double;
   logic        is_to;
   logic        was_c;
   logic        was_second;
   assign is_double = (link.cp_op == CRT_OP_DFROM) ||
                      (link.cp_op == CRT_OP_DTO);
   assign is_to = (link.cp_op == CRT_OP_TO) ||
                  (link.cp_op == CRT_OP_DTO);
   // Answers: ABSENT unless handling a present instruction
   always_comb begin
      link.decode_handshake = CRT_ABSENT; // RULE10
      link.execute_handshake = CRT_ABSENT; // RULE10
      if (link.cp_instr_valid && cp_present) begin
         if (!cp_ready) begin
            link.decode_handshake = CRT_WAIT; // RULE7
            link.execute_handshake = CRT_WAIT; // RULE7
         end else if (is_double && !first_done &&
                      link.data_req != CRT_REQ_C) begin
            // GO on both decode and execute handshakes until the first C cycle; LAST from that cycle on
            link.decode_handshake = CRT_GO; // RULE5 RULE6
            link.execute_handshake = CRT_GO;
         end else begin
            link.decode_handshake = CRT_LAST; // RULE1 RULE3
            link.execute_handshake = CRT_LAST;
         end
      end
   end
   // Tracks first of two words in a double transfer
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !link.cp_instr_valid) begin
         first_done <= 1'b0;
      end else if (link.data_req == CRT_REQ_C) begin
         first_done <= 1'b1;
      end
   end
   // Read data registered out of each coprocessor cycle, presented one clock later
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         link.rdata <= CRT_DATA_RST;
      end else begin
         link.rdata <= first_done ? cp_word1 : cp_word0; // RULE2
      end
   end
   // Write data follows the coprocessor cycle by one clock
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         was_c <= 1'b0;
         was_second <= 1'b0;
         cp_got0 <= CRT_DATA_RST;
         cp_got1 <= CRT_DATA_RST;
         cp_got_pulse <= 1'b0;
      end else begin
         was_c <= (link.data_req == CRT_REQ_C) && is_to;
         // Word index of the cycle just ended; first_done moves on with it
         was_second <= first_done;
         cp_got_pulse <= was_c;
         if (was_c && !was_second) begin
            cp_got0 <= link.wdata; // RULE3
         end
         if (was_c && was_second) begin
            cp_got1 <= link.wdata; // RULE6
         end
      end
   end
endmodule

/* File: crt_core_end.sv */
// Core end: sequencing of coprocessor register transfers
`timescale 1ns/10ps
module crt_core_end (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   // Link
   crt_if.core                    link,
   // Instruction issue
   input  wire logic              issue_valid,
   input  wire crt_pkg::crt_op_type issue_op,
   input  wire logic              wide_isa_state,
   input  wire logic              irq_pending,
   input  wire logic [31:0]       src_first,
   input  wire logic [31:0]       src_second,
   input  wire logic [30:0]       pc_addr,
   // Results
   output logic                   busy,
   output logic                   done_pulse,
   output logic                   undef_pulse,
   output logic                   abandon_pulse,
   output logic [31:0]            dest_first,
   output logic [31:0]            dest_second,
   output logic [30:0]            instruction_address,
   output logic                   data_addr_valid
);
   import crt_pkg::*;
   typedef enum {
      ST_IDLE,
      ST_DECODE,
      ST_WAIT,
      ST_XFER1,
      ST_XFER2,
      ST_DRAIN
   } crt_state_type;
   crt_state_type state;
   crt_state_type next_state;
   crt_op_type    op;
   logic          is_double;
   logic          is_to;
   logic          xfer;
   logic          second;
   crt_hs_type    hs;
   function automatic logic op_double(input crt_op_type o);
      op_double = (o == CRT_OP_DFROM) || (o == CRT_OP_DTO);
   endfunction
   function automatic logic op_to(input crt_op_type o);
      op_to = (o == CRT_OP_TO) || (o == CRT_OP_DTO);
   endfunction
   assign is_double = op_double(op);
   assign is_to = op_to(op);
   assign xfer = (state == ST_XFER1) || (state == ST_XFER2);
   assign hs = (state == ST_DECODE) ? link.decode_handshake
                                    : link.execute_handshake;
   ////////////////////////////////////////////////////////////////////
   // Next transfer state
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (issue_valid && wide_isa_state) begin // RULE8
               next_state = ST_DECODE;
            end
         end
         ST_DECODE, ST_WAIT: begin
            case (hs)
               CRT_ABSENT: begin
                  // No coprocessor took it: leave for the undefined trap
                  next_state = ST_IDLE; // RULE11
               end
               CRT_WAIT: begin
                  // Busy-wait; a pending interrupt abandons the instruction
                  if (irq_pending) begin
                     next_state = ST_IDLE; // RULE7
                  end else begin
                     next_state = ST_WAIT; // RULE7
                  end
               end
               CRT_GO: begin
                  // GO only starts a double; a single keeps waiting for LAST
                  if (is_double) begin
                     next_state = ST_XFER1; // RULE5 RULE6
                  end else begin
                     next_state = ST_WAIT;
                  end
               end
               CRT_LAST: begin
                  // A single needs one coprocessor cycle only
                  if (is_double) begin
                     next_state = ST_XFER1;
                  end else begin
                     next_state = ST_XFER2; // RULE1 RULE3
                  end
               end
               default: begin
                  next_state = ST_IDLE;
               end
            endcase
         end
         ST_XFER1: next_state = ST_XFER2; // RULE5 RULE6
         ST_XFER2: next_state = ST_DRAIN;
         ST_DRAIN: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end
   // Operation latched at issue, held for the whole transfer
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         op <= CRT_OP_FROM;
      end else if (state == ST_IDLE && issue_valid) begin
         op <= issue_op;
      end
   end
   // Address frozen while busy-waiting or transferring
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         instruction_address <= '0;
      end else if (state == ST_IDLE && issue_valid) begin
         instruction_address <= pc_addr; // RULE7
      end
   end
   ////////////////////////////////////////////////////////////////////
   assign link.cp_instr_valid = (state != ST_IDLE) && (state != ST_DRAIN);
   assign link.cp_op = op;
   assign link.pass = 1'b1; // RULE9
   assign link.cancel_after_issue = 1'b0; // RULE9
   // Coprocessor cycle flagged on the data request lines
   assign link.data_req = xfer ? CRT_REQ_C : CRT_REQ_I; // RULE1 RULE7
   assign link.instr_req = (state == ST_XFER2) ? CRT_REQ_S : CRT_REQ_I;
   assign data_addr_valid = 1'b0; // RULE4
   assign busy = (state != ST_IDLE);
   assign second = (state == ST_XFER2) && is_double;
   ////////////////////////////////////////////////////////////////////
   // Store-timed write data: drives the word of the previous cycle
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         link.wdata <= CRT_DATA_RST;
      end else if (xfer && is_to) begin
         link.wdata <= second ? src_second : src_first; // RULE3 RULE4 RULE6
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Load-timed capture one cycle after the C cycle, since the
   // coprocessor registers its word out of that cycle
   logic cap_pending;
   logic cap_second;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cap_pending <= 1'b0;
      end else begin
         cap_pending <= xfer && !is_to;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cap_second <= 1'b0;
      end else begin
         cap_second <= second;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         dest_first <= CRT_DATA_RST;
      end else if (cap_pending && !cap_second) begin
         dest_first <= link.rdata; // RULE1 RULE2 RULE5
      end
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         dest_second <= CRT_DATA_RST;
      end else if (cap_pending && cap_second) begin
         dest_second <= link.rdata; // RULE5
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Decode or busy-wait: the handshake decides what follows
   logic waiting;
   assign waiting = (state == ST_DECODE) || (state == ST_WAIT);
   // Completion one cycle after the drain state
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         done_pulse <= 1'b0;
      end else begin
         done_pulse <= (state == ST_DRAIN);
      end
   end
   // Nobody answered: software must emulate the instruction
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         undef_pulse <= 1'b0;
      end else begin
         undef_pulse <= waiting && hs == CRT_ABSENT; // RULE11
      end
   end
   // Abandon only from a busy-wait, never once data has moved
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         abandon_pulse <= 1'b0;
      end else begin
         abandon_pulse <= waiting && hs == CRT_WAIT && irq_pending; // RULE7
      end
   end
endmodule

/* File: crt_properties.sv */
// Checker for the coprocessor register transfer link
`timescale 1ns/10ps
module crt_properties (
   // Clock and reset
   input wire logic                sys_clk,
   input wire logic                sys_rst,
   // Link
   input wire crt_pkg::crt_hs_type decode_handshake,
   input wire crt_pkg::crt_hs_type execute_handshake,
   input wire logic                cp_instr_valid,
   input wire crt_pkg::crt_op_type cp_op,
   input wire logic                pass,
   input wire logic                cancel_after_issue,
   input wire logic [1:0]          data_req,
   input wire logic [1:0]          instr_req
);
   import crt_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////
   a_pass_fixed: assert property (pass && !cancel_after_issue)
      else $error("pass or cancel wrong");
   a_wait_idle: assert property (execute_handshake == CRT_WAIT
      |-> data_req == CRT_REQ_I && instr_req == CRT_REQ_I)
      else $error("request not idle while waiting");
   a_last_gives_c: assert property ((decode_handshake == CRT_LAST
      || execute_handshake == CRT_LAST) && data_req != CRT_REQ_C
      |=> data_req == CRT_REQ_C) else $error("no cycle after last");
   a_go_two_c: assert property ((decode_handshake == CRT_GO
      || execute_handshake == CRT_GO) && data_req != CRT_REQ_C
      |=> (data_req == CRT_REQ_C) [*2] ##1 data_req != CRT_REQ_C)
      else $error("double move not two cycles");
   a_single_once: assert property (data_req == CRT_REQ_C
      && (cp_op == CRT_OP_FROM || cp_op == CRT_OP_TO)
      |=> data_req != CRT_REQ_C) else $error("single move too long");
   a_absent_idle: assert property (!cp_instr_valid
      |-> decode_handshake == CRT_ABSENT && execute_handshake == CRT_ABSENT)
      else $error("handshake not absent");
   a_last_c_seq: assert property (data_req == CRT_REQ_C
      ##1 data_req != CRT_REQ_C |-> $past(instr_req) == CRT_REQ_S)
      else $error("last cycle fetch not sequential");
   a_c_no_wait: assert property (data_req == CRT_REQ_C
      |-> execute_handshake != CRT_WAIT) else $error("cycle during wait");
   c_single: cover property (data_req == CRT_REQ_C && cp_op == CRT_OP_TO);
   c_double: cover property ((data_req == CRT_REQ_C) [*2]);
   c_wait: cover property ((execute_handshake == CRT_WAIT) [*3]);
endmodule

/* File: coproc_register_transfer_test.sv */
// Testbench for both ends of the coprocessor register transfer port
`timescale 1ns/10ps
module coproc_register_transfer_test;
   import crt_pkg::*;
   logic        sys_clk = 0, sys_rst = 1, issue_valid = 0, wide_isa_state = 1;
   logic        irq_pending = 0, cp_present = 1, cp_ready = 1;
   crt_op_type  issue_op = CRT_OP_FROM;
   logic [31:0] src_first = 0, src_second = 0, cp_word0 = 0, cp_word1 = 0;
   logic [30:0] pc_addr = 0;
   logic        busy, done_pulse, undef_pulse, abandon_pulse, data_addr_valid;
   logic        cp_got_pulse;
   logic [31:0] dest_first, dest_second, cp_got0, cp_got1;
   logic [30:0] instruction_address;
   logic [31:0] exp_q[$];
   int          bad_count = 0, check_count = 0, got_n = 0, s;
   crt_if u_crt_if ();
   crt_core_end u_crt_core_end (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .link(u_crt_if), .issue_valid(issue_valid), .issue_op(issue_op),
      .wide_isa_state(wide_isa_state), .irq_pending(irq_pending),
      .src_first(src_first), .src_second(src_second), .pc_addr(pc_addr),
      .busy(busy), .done_pulse(done_pulse), .undef_pulse(undef_pulse),
      .abandon_pulse(abandon_pulse), .dest_first(dest_first),
      .dest_second(dest_second), .instruction_address(instruction_address),
      .data_addr_valid(data_addr_valid));
   crt_coproc_end u_crt_coproc_end (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .link(u_crt_if), .cp_present(cp_present), .cp_ready(cp_ready),
      .cp_word0(cp_word0), .cp_word1(cp_word1), .cp_got0(cp_got0),
      .cp_got1(cp_got1), .cp_got_pulse(cp_got_pulse));
   crt_properties u_crt_properties (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .decode_handshake(u_crt_if.decode_handshake),
      .execute_handshake(u_crt_if.execute_handshake),
      .cp_instr_valid(u_crt_if.cp_instr_valid), .cp_op(u_crt_if.cp_op),
      .pass(u_crt_if.pass), .cancel_after_issue(u_crt_if.cancel_after_issue),
      .data_req(u_crt_if.data_req), .instr_req(u_crt_if.instr_req));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      forever #10 sys_clk = ~sys_clk;
   end
   // Counts words taken in by the coprocessor end
   always @(posedge sys_clk) begin
      if (cp_got_pulse === 1'b1) got_n <= got_n + 1;
   end
   task automatic chk_word(input string nm, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %0s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_bit(input string nm, input logic g);
      chk_word(nm, 32'h1, {31'h0, g});
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // One transfer; stall is the count of WAIT cycles before ready
   task automatic run(input crt_op_type op, input logic pres, irq,
                      input int stall);
      int n;
      int got_base;
      int exp_got;
      logic [30:0] exp_addr;
      src_first = $urandom;
      src_second = $urandom;
      cp_word0 = $urandom;
      cp_word1 = $urandom;
      pc_addr = 31'($urandom);
      exp_addr = pc_addr;
      got_base = got_n;
      exp_got = 0;
      if (pres && !irq && op == CRT_OP_TO) exp_got = 1;
      if (pres && !irq && op == CRT_OP_DTO) exp_got = 2;
      issue_op = op;
      cp_present = pres;
      irq_pending = irq;
      cp_ready = (stall == 0);
      if (op == CRT_OP_FROM || op == CRT_OP_DFROM)
         exp_q = '{cp_word0, cp_word1};
      else
         exp_q = '{src_first, src_second};
      issue_valid = 1;
      @(posedge sys_clk);
      #1 issue_valid = 0;
      for (n = 0; n < 60 && !(done_pulse || undef_pulse || abandon_pulse);
           n++) begin
         if (n == stall) cp_ready = 1;
         if (busy === 1'b1) chk_word("addr", {1'b0, exp_addr},
                                     {1'b0, instruction_address});
         chk_bit("no data addr", !data_addr_valid);
         // Moving fetch address must not reach the held one
         pc_addr = 31'($urandom);
         @(posedge sys_clk);
         #1;
      end
      if (!pres) chk_bit("undefined", undef_pulse);
      else if (irq) chk_bit("abandon", abandon_pulse);
      else chk_bit("done", done_pulse);
      repeat (2) @(posedge sys_clk);
      #1 irq_pending = 0;
      cp_ready = 1;
      chk_word("got pulses", 32'(exp_got), 32'(got_n - got_base));
      if (pres && !irq) begin
         if (op == CRT_OP_FROM || op == CRT_OP_DFROM)
            chk_word("dest first", exp_q[0], dest_first);
         else chk_word("got first", exp_q[0], cp_got0);
         if (op == CRT_OP_DFROM)
            chk_word("dest second", exp_q[1], dest_second);
         if (op == CRT_OP_DTO)
            chk_word("got second", exp_q[1], cp_got1);
      end
      $display("test op %0d present %0d irq %0d ends", op, pres, irq);
   endtask
   initial begin
      #40000;
      bad_count++;
      tally_and_finish;
   end
   initial begin
      s = $urandom(32'haafa);
      repeat (6) @(posedge sys_clk);
      #1 sys_rst = 0;
      for (int i = 0; i < 8; i++) run(crt_op_type'(i % 4), 1, 0, i / 4 * 3);
      run(CRT_OP_DTO, 1, 0, 1);
      run(CRT_OP_FROM, 0, 0, 0);
      run(CRT_OP_TO, 1, 1, 99);
      // Compressed state must ignore the issue
      wide_isa_state = 0;
      issue_valid = 1;
      repeat (5) @(posedge sys_clk);
      #1 chk_bit("not busy", !busy);
      issue_valid = 0;
      wide_isa_state = 1;
      $display("test compressed state ends");
      tally_and_finish;
   end
endmodule
